// file: logic/ssm_monitor.sv
// servo supervision monitor: window comparators, error timers,
// compensator terms, fault history and three-button menu
// assumes inputs synchronous to clk_i, buttons as one-cycle presses
//
// Our own choices: the address map and the strobed register port.
`default_nettype none
module ssm_monitor #(
    parameter int unsigned MS_CYC    = ssm_pkg::SSM_MS_CYC,
    parameter int unsigned SERVO_CYC = ssm_pkg::SSM_SERVO_CYC
) (
    input  wire logic                   clk_i,
    input  wire logic                   reset_n_i,
    input  wire ssm_pkg::ssm_bus_type   bus_i,
    input  wire ssm_pkg::ssm_fb_type    fb_i,
    input  wire ssm_pkg::ssm_panel_type panel_i,
    input  wire ssm_pkg::ssm_plant_type plant_i,
    input  wire logic                   fault_i,
    input  wire logic [7:0]             fault_code_i,
    output logic [15:0]                 rdata_o,
    output logic                        zero_speed_o,
    output logic                        speed_window_hit_o,
    output logic                        fault_o,
    output logic                        drive_en_o,
    output logic signed [15:0]          comp_o,
    output logic [1:0]                  baud_o,
    output logic                        data_led_o,
    output ssm_pkg::ssm_disp_type       disp_o
);
    import ssm_pkg::*;

    typedef struct packed {
        logic [14:0][15:0]  cfg;
        logic [15:0]        rdata;
        logic [12:0]        scnt;
        logic [16:0]        mcnt;
        logic [15:0]        pe_t;
        logic [15:0]        pe2_t;
        logic               flt;
        logic               en;
        logic               zs;
        logic               asw;
        logic [7:0]         fcode;
        logic [7:0][7:0]    hist;
        logic signed [31:0] vint;
        logic signed [31:0] pint;
        logic signed [15:0] perr_p;
        logic signed [15:0] comp;
        ssm_menu_type       menu;
        logic [2:0]         ent;
        logic [2:0]         hidx;
        logic [1:0]         baud;
        logic [1:0]         ebaud;
        logic [7:0]         blink;
        logic               led;
        ssm_disp_type       disp;
    } ssm_state_type;

    ssm_state_type q;
    ssm_state_type d;

    function automatic logic [15:0] absv(input logic signed [15:0] x);
        return x[15] ? 16'(-x) : 16'(x);
    endfunction

    function automatic logic signed [31:0] mulg(input logic signed [15:0] a,
                                                input logic [7:0] g);
        return 32'(a) * 32'($signed({1'b0, g}));
    endfunction

    function automatic logic signed [15:0] sat16(input logic signed [31:0] x);
        if (x > 32'sh0000_7FFF) begin
            return 16'sh7FFF;
        end else if (x < -32'sh0000_8000) begin
            return 16'sh8000;
        end
        return 16'(x);
    endfunction

    function automatic logic signed [31:0] clampv(input logic signed [32:0] x,
                                                  input logic signed [31:0] lim);
        if (x > 33'(lim)) begin
            return lim;
        end else if (x < -33'(lim)) begin
            return -lim;
        end
        return 32'(x);
    endfunction

    logic [1:0]         mode;
    logic [3:0]         win;
    logic               dual;
    logic               ctl_en;
    logic               tick_s;
    logic               tick_m;
    logic [15:0]        spd_a;
    logic [16:0]        half;
    logic signed [15:0] verr;
    logic signed [15:0] perr;
    logic signed [31:0] vg;
    logic signed [31:0] pterm;
    logic signed [31:0] ilim;
    logic               over1;
    logic               over2;
    logic               pe_ev;
    logic               ev;
    logic [7:0]         evcode;
    logic               hclr;
    logic [15:0]        st;

    always_comb begin
        d      = q;
        mode   = q.cfg[REG_CTRL][CTRL_MODE_LSB +: 2];
        win    = q.cfg[REG_CTRL][CTRL_WIN_LSB +: 4];
        dual   = q.cfg[REG_CTRL][CTRL_DUAL];
        ctl_en = q.cfg[REG_CTRL][CTRL_EN];
        tick_s = q.scnt == 13'(SERVO_CYC - 1);
        tick_m = q.mcnt == 17'(MS_CYC - 1);
        spd_a  = absv(fb_i.speed);
        half   = 17'(q.cfg[REG_AT_WID][15:1]);
        verr   = sat16(32'(fb_i.vel_cmd) - 32'(fb_i.speed));
        perr   = 16'(fb_i.pos_cmd - fb_i.pos_act);
        vg     = '0;
        pterm  = '0;
        ilim   = $signed(32'(q.cfg[REG_POS_ILIM][7:0])) * POS_ILIM_UNIT;
        ilim   = ilim <<< GAIN_SHIFT;
        hclr   = bus_i.we && bus_i.addr == REG_CMD && bus_i.wdata[CMD_HCLR];
        st     = '0;

        // slow rates as one-cycle enables
        d.scnt  = tick_s ? '0 : q.scnt + 13'h0001;
        d.mcnt  = tick_m ? '0 : q.mcnt + 17'h00001;
        d.blink = tick_m ? q.blink + 8'h01 : q.blink;

        // register port
        if (bus_i.we && bus_i.addr < REG_CMD) begin
            d.cfg[bus_i.addr[3:0]] = bus_i.wdata;
        end
        st[STAT_FAULT] = q.flt;
        st[STAT_EN]    = q.en;
        st[STAT_ZS]    = q.zs;
        st[STAT_AS]    = q.asw;
        st[STAT_CODE_LSB +: 8] = q.fcode;
        d.rdata = '0;
        if (bus_i.re) begin
            if (bus_i.addr < REG_CMD) begin
                d.rdata = q.cfg[bus_i.addr[3:0]];
            end else if (bus_i.addr == REG_CMD) begin
                d.rdata = st;
            end else if (bus_i.addr < REG_COMP) begin
                d.rdata = {8'h00, q.hist[bus_i.addr[2:0]]};
            end else if (bus_i.addr == REG_COMP) begin
                d.rdata = q.comp;
            end
        end

        // speed comparators
        d.zs  = mode == MODE_VEL && spd_a <= q.cfg[REG_ZERO_SPD];
        d.asw = mode == MODE_VEL
                && 17'(spd_a) + half >= 17'(q.cfg[REG_AT_CTR])
                && 17'(spd_a) <= 17'(q.cfg[REG_AT_CTR]) + half;

        // error timers run in ms ticks; coarse by up to one tick
        over1 = q.en && absv(perr) > q.cfg[REG_PE_LIM];
        over2 = q.en && dual && absv(fb_i.pos2_err) > q.cfg[REG_PE2_LIM];
        if (!over1) begin
            d.pe_t = '0;
        end else if (tick_m && q.pe_t != 16'hFFFF) begin
            d.pe_t = q.pe_t + 16'h0001;
        end
        if (!over2) begin
            d.pe2_t = '0;
        end else if (tick_m && q.pe2_t != 16'hFFFF) begin
            d.pe2_t = q.pe2_t + 16'h0001;
        end
        pe_ev = !q.flt && ((over1 && q.pe_t > q.cfg[REG_PE_TIME])
                || (over2 && q.pe2_t > q.cfg[REG_PE2_TIME]));

        // fault event: external code wins a tie
        ev     = fault_i || pe_ev;
        evcode = fault_i ? fault_code_i : FC_POS_ERR;
        if (hclr) begin
            d.hist = '0;
        end
        if (ev) begin
            d.hist  = {d.hist[6:0], evcode};
            d.flt   = 1'b1;
            d.fcode = evcode;
        end else if (!ctl_en) begin
            d.flt = 1'b0;
        end
        d.en = d.cfg[REG_CTRL][CTRL_EN] && !d.flt;

        // compensator, once per servo cycle
        if (tick_s) begin
            if (q.en) begin
                d.vint = clampv(33'(q.vint) + 33'(mulg(verr, q.cfg[REG_VEL_KI][7:0])),
                                VINT_MAX);
            end else begin
                d.vint = '0;
            end
            vg = (mulg(verr, q.cfg[REG_VEL_KP][7:0]) + q.vint) >>> GAIN_SHIFT;
            vg = 32'(sat16(vg)) <<< win;
            if (q.en && mode == MODE_POS) begin
                d.pint = clampv(33'(q.pint) + 33'(mulg(perr,
                         dual ? q.cfg[REG_POS2_KI][7:0]
                              : q.cfg[REG_POS_KI][7:0])), ilim);
                pterm = mulg(sat16(32'(perr) - 32'(q.perr_p)),
                             q.cfg[REG_POS_KD][7:0]);
                pterm = (pterm + mulg(perr, q.cfg[REG_POS_KP][7:0])
                         + q.pint) >>> GAIN_SHIFT;
                d.perr_p = perr;
            end else begin
                d.pint   = '0;
                d.perr_p = '0;
            end
            d.comp = sat16(vg + pterm);
        end

        // front-panel menu; enter outranks up/down
        case (q.menu)
            MS_SCROLL: begin
                if (panel_i.ent) begin
                    d.hidx  = '0;
                    d.ebaud = q.baud;
                    d.menu  = q.ent == BAUD_ENTRY ? MS_EDIT : MS_VIEW;
                end else if (panel_i.up) begin
                    d.ent = q.ent + 3'h1;
                end else if (panel_i.dn) begin
                    d.ent = q.ent - 3'h1;
                end
            end
            MS_VIEW: begin
                if (panel_i.ent) begin
                    d.menu = MS_SCROLL;
                end else if (q.ent == FAULT_HISTORY_ENTRY && panel_i.up) begin
                    d.hidx = q.hidx + 3'h1;
                end else if (q.ent == FAULT_HISTORY_ENTRY && panel_i.dn) begin
                    d.hidx = q.hidx - 3'h1;
                end
            end
            MS_EDIT: begin
                if (panel_i.ent) begin
                    d.baud = q.ebaud;
                    d.menu = MS_SCROLL;
                end else if (panel_i.up && q.ebaud != BAUD_9K6) begin
                    d.ebaud = q.ebaud + 2'h1;
                end else if (panel_i.dn && q.ebaud != BAUD_38K4) begin
                    d.ebaud = q.ebaud - 2'h1;
                end
            end
            default: begin
                d.menu = MS_SCROLL;
            end
        endcase
        d.led = d.menu == MS_EDIT && q.blink[SSM_BLINK_BIT];

        // display content follows the next state
        d.disp = '{kind: DK_NAME, idx: 3'h0, val: {13'h0000, d.ent}};
        if (d.menu != MS_SCROLL) begin
            case (d.ent)
                DRIVE_STATUS_ENTRY: begin
                    d.disp.kind = d.flt ? FAULT_CODE_DISPLAY : d.en ? DK_RUN : DK_DIS;
                    d.disp.val  = d.flt ? {8'h00, d.fcode} : 16'h0000;
                end
                BAUD_ENTRY: begin
                    d.disp.kind = DK_BAUD;
                    d.disp.val  = {14'h0000, d.menu == MS_EDIT ? d.ebaud : d.baud};
                end
                FAULT_HISTORY_ENTRY: begin
                    d.disp.kind = DK_HIST;
                    d.disp.idx  = d.hidx;
                    d.disp.val  = {8'h00, d.hist[d.hidx]};
                end
                HEATSINK_TEMP_ENTRY: begin
                    d.disp.kind = plant_i.temp > TEMP_LOW_C ? DK_TEMP : LOW_TEMP_INDICATION;
                    d.disp.val  = plant_i.temp > TEMP_LOW_C ? {8'h00, plant_i.temp} : 16'h0000;
                end
                ENCODER_COUNT_ENTRY: begin
                    d.disp.kind = DK_ENC;
                    d.disp.val  = fb_i.pos_act;
                end
                HALL_ENTRY: begin
                    d.disp.kind = DK_HALL;
                    d.disp.val  = {4'h0, 3'h0, plant_i.hall[2], 3'h0, plant_i.hall[1],
                                   3'h0, plant_i.hall[0]};
                end
                DC_LINK_VOLTAGE_ENTRY: begin
                    d.disp.kind = DK_DCV;
                    d.disp.val  = plant_i.dcv;
                end
                default: begin
                    d.disp.kind = d.en ? DK_CUR : DK_CUR_DIS;
                    d.disp.val  = d.en ? plant_i.irms : 16'h0000;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!reset_n_i) begin
            q      <= '0;
            q.cfg  <= {15{CFG_RST}};
            q.menu <= MS_SCROLL;
        end else begin
            q <= d;
        end
    end

    assign rdata_o            = q.rdata;
    assign zero_speed_o       = q.zs;
    assign speed_window_hit_o = q.asw;
    assign fault_o            = q.flt;
    assign drive_en_o         = q.en;
    assign comp_o             = q.comp;
    assign baud_o             = q.baud;
    assign data_led_o         = q.led;
    assign disp_o             = q.disp;

    // checks stay beside the logic they guard
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    AST_MODE_GATE: assert property (mode != MODE_VEL |=> !zero_speed_o && !speed_window_hit_o)
        else $error("speed flag set outside velocity mode");
    AST_ZERO_SPD: assert property (mode == MODE_VEL && spd_a <= q.cfg[REG_ZERO_SPD]
        |=> zero_speed_o)
        else $error("zero speed missed");
    AST_TIMER_RESTART: assert property (!over1 |=> q.pe_t == 16'h0000)
        else $error("error timer not restarted");
    AST_PE_FAULT: assert property (!q.flt && over1 && q.pe_t > q.cfg[REG_PE_TIME]
        |=> fault_o && !drive_en_o)
        else $error("position error excess fault missed");
    AST_FAULT_OFF: assert property (fault_i |=> fault_o ##0 !drive_en_o
        ##0 q.fcode == $past(fault_code_i))
        else $error("fault did not disable drive");
    AST_HIST_PUSH: assert property (ev && !hclr |=> q.hist[0] == $past(evcode)
        && q.hist[1] == $past(q.hist[0]))
        else $error("history push wrong");
    AST_HIST_CLR: assert property (hclr && !ev |=> q.hist == '0)
        else $error("history not cleared");
    AST_POS_ONLY: assert property (mode != MODE_POS && tick_s |=> q.pint == 32'sh0)
        else $error("position integral active outside position mode");
    AST_MENU_VIEW: assert property (q.menu == MS_SCROLL && panel_i.ent
        && q.ent != BAUD_ENTRY |=> q.menu == MS_VIEW)
        else $error("enter did not open view");
    AST_BAUD_RANGE: assert property (baud_o <= BAUD_9K6 && q.ebaud <= BAUD_9K6)
        else $error("baud selection out of range");
    AST_CUR_DIS: assert property (!d.en && d.menu != MS_SCROLL
        && d.ent == PHASE_CURRENT_ENTRY |=> disp_o.kind == DK_CUR_DIS)
        else $error("current shown while disabled");

    COV_EDIT: cover property (q.menu == MS_EDIT && panel_i.ent);
    COV_PE: cover property (pe_ev);
    COV_SPEED_WINDOW_HIT: cover property (speed_window_hit_o ##1 !speed_window_hit_o);
    COV_HIST_FULL: cover property (ev && q.hist[7] != 8'h00);
endmodule
`default_nettype wire

// file: logic/ssm_pkg.sv
// servo supervision monitor: shared constants, carrier structs
// assumes one 100 MHz clock and a word-indexed register port
`default_nettype none
package ssm_pkg;
    localparam int SSM_CLK_MHZ   = 100;
    localparam int SSM_MS_US     = 1000;
    localparam int SSM_MS_CYC    = SSM_CLK_MHZ * SSM_MS_US;
    localparam int SSM_SERVO_US  = 50;
    localparam int SSM_SERVO_CYC = SSM_CLK_MHZ * SSM_SERVO_US;
    localparam int SSM_BLINK_BIT = 7;
    localparam int GAIN_SHIFT    = 8;
    // register word indices
    localparam logic [4:0] REG_CTRL     = 5'h00;
    localparam logic [4:0] REG_ZERO_SPD = 5'h01;
    localparam logic [4:0] REG_AT_CTR   = 5'h02;
    localparam logic [4:0] REG_AT_WID   = 5'h03;
    localparam logic [4:0] REG_PE_LIM   = 5'h04;
    localparam logic [4:0] REG_PE_TIME  = 5'h05;
    localparam logic [4:0] REG_PE2_LIM  = 5'h06;
    localparam logic [4:0] REG_PE2_TIME = 5'h07;
    localparam logic [4:0] REG_VEL_KP   = 5'h08;
    localparam logic [4:0] REG_VEL_KI   = 5'h09;
    localparam logic [4:0] REG_POS_KP   = 5'h0A;
    localparam logic [4:0] REG_POS_KI   = 5'h0B;
    localparam logic [4:0] REG_POS_KD   = 5'h0C;
    localparam logic [4:0] REG_POS_ILIM = 5'h0D;
    localparam logic [4:0] REG_POS2_KI  = 5'h0E;
    localparam logic [4:0] REG_CMD      = 5'h0F;
    localparam logic [4:0] REG_HIST0    = 5'h10;
    localparam logic [4:0] REG_COMP     = 5'h18;
    localparam logic [15:0] CFG_RST     = 16'h0000;
    // field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_DUAL     = 2;
    localparam int CTRL_EN       = 4;
    localparam int CTRL_WIN_LSB  = 8;
    localparam int CMD_HCLR      = 0;
    localparam int STAT_FAULT    = 0;
    localparam int STAT_EN       = 1;
    localparam int STAT_ZS       = 2;
    localparam int STAT_AS       = 3;
    localparam int STAT_CODE_LSB = 8;
    localparam logic [1:0] MODE_TORQUE = 2'h0;
    localparam logic [1:0] MODE_VEL    = 2'h1;
    localparam logic [1:0] MODE_POS    = 2'h2;
    localparam logic [7:0] FC_POS_ERR  = 8'h07;
    localparam logic [7:0] TEMP_LOW_C  = 8'h28;
    localparam logic signed [31:0] POS_ILIM_UNIT = 32'sh0000_0147;
    localparam logic signed [31:0] VINT_MAX      = 32'sh3FFF_FFFF;
    // menu entries
    localparam logic [2:0] DRIVE_STATUS_ENTRY    = 3'h0;
    localparam logic [2:0] BAUD_ENTRY            = 3'h1;
    localparam logic [2:0] FAULT_HISTORY_ENTRY   = 3'h2;
    localparam logic [2:0] HEATSINK_TEMP_ENTRY   = 3'h3;
    localparam logic [2:0] ENCODER_COUNT_ENTRY   = 3'h4;
    localparam logic [2:0] HALL_ENTRY            = 3'h5;
    localparam logic [2:0] DC_LINK_VOLTAGE_ENTRY = 3'h6;
    localparam logic [2:0] PHASE_CURRENT_ENTRY   = 3'h7;
    // display kinds
    localparam logic [3:0] DK_NAME  = 4'h0;
    localparam logic [3:0] DK_RUN   = 4'h1;
    localparam logic [3:0] DK_DIS   = 4'h2;
    localparam logic [3:0] FAULT_CODE_DISPLAY  = 4'h3;
    localparam logic [3:0] DK_BAUD  = 4'h4;
    localparam logic [3:0] DK_HIST  = 4'h5;
    localparam logic [3:0] DK_TEMP  = 4'h6;
    localparam logic [3:0] LOW_TEMP_INDICATION = 4'h7;
    localparam logic [3:0] DK_ENC   = 4'h8;
    localparam logic [3:0] DK_HALL  = 4'h9;
    localparam logic [3:0] DK_DCV   = 4'hA;
    localparam logic [3:0] DK_CUR   = 4'hB;
    localparam logic [3:0] DK_CUR_DIS = 4'hC;
    localparam logic [1:0] BAUD_38K4 = 2'h0;
    localparam logic [1:0] BAUD_9K6  = 2'h2;
    typedef enum logic [2:0] {
        MS_SCROLL = 3'b001,
        MS_VIEW   = 3'b010,
        MS_EDIT   = 3'b100
    } ssm_menu_type;
    typedef struct packed {
        logic [4:0]  addr;
        logic [15:0] wdata;
        logic        we;
        logic        re;
    } ssm_bus_type;
    typedef struct packed {
        logic signed [15:0] speed;
        logic signed [15:0] vel_cmd;
        logic signed [15:0] pos_cmd;
        logic signed [15:0] pos_act;
        logic signed [15:0] pos2_err;
    } ssm_fb_type;
    typedef struct packed {
        logic up;
        logic dn;
        logic ent;
    } ssm_panel_type;
    typedef struct packed {
        logic [7:0]  temp;
        logic [15:0] dcv;
        logic [15:0] irms;
        logic [2:0]  hall;
    } ssm_plant_type;
    typedef struct packed {
        logic [3:0]  kind;
        logic [2:0]  idx;
        logic [15:0] val;
    } ssm_disp_type;
endpackage
`default_nettype wire

// file: verif/servo_supervision_monitor_bench.sv
// bench: random and corner stimulus for the supervision monitor
// assumes shortened ms and servo counts, one clock
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module servo_supervision_monitor_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ssm_pkg::*;
    logic               clk_i = 1'b0, reset_n_i = 1'b0, fault_i = 1'b0;
    logic [7:0]         code = 8'h00;
    logic signed [15:0] spd = 16'sh0000, cmd = 16'sh0000, comp;
    ssm_bus_type        bus = '0;
    ssm_panel_type      pan = '0;
    ssm_plant_type      plant = '0;
    ssm_fb_type         fb;
    ssm_disp_type       disp;
    logic [15:0]        rdata;
    logic               zs, ash, flt, en, led;
    logic [1:0]         baud;
    int                 err_count = 0, check_count = 0, cyc = 0, s;
    int                 sp[6] = '{50, 51, 950, 1050, 949, 1051};
    logic [7:0]         hq[$];
    ssm_monitor #(.MS_CYC(10), .SERVO_CYC(4)) ssm_monitor_i (.clk_i(clk_i),
        .reset_n_i(reset_n_i), .bus_i(bus), .fb_i(fb), .panel_i(pan), .plant_i(plant),
        .fault_i(fault_i), .fault_code_i(code), .rdata_o(rdata), .zero_speed_o(zs),
        .speed_window_hit_o(ash), .fault_o(flt), .drive_en_o(en), .comp_o(comp),
        .baud_o(baud), .data_led_o(led), .disp_o(disp));
    ssm_motor_model ssm_motor_model_i (.clk_i(clk_i), .drive_en_i(en), .spd_i(spd),
        .cmd_i(cmd), .fb_o(fb));
    initial forever #5 clk_i = ~clk_i;
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // ceiling well above the longest run, which sits near 1350 cycles
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_i);
        bus <= '{a, d, 1'b1, 1'b0};
        wt(1);
        bus.we <= 1'b0;
    endtask
    task automatic rc(input logic [4:0] a, input logic [15:0] e);
        @(posedge clk_i);
        bus <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk_i);
        bus.re <= 1'b0;
        // read data stand only in the cycle after the strobe edge
        #1;
        `CHK("rdata", e, rdata)
    endtask
    // one-cycle press: 0 enter, 1 down, 2 up
    task automatic press(input int b);
        @(posedge clk_i);
        pan[b] <= 1'b1;
        wt(1);
        pan <= '0;
    endtask
    function automatic logic exp_as(input int x);
        return x >= 950 && x <= 1050;
    endfunction
    function automatic logic [15:0] exp_p(input int e, input int k);
        return 16'((e * k) >>> 8);
    endfunction
    initial begin
        void'($urandom(67));
        plant.temp <= 8'($urandom_range(40));
        plant.hall <= 3'b101;
        wt(10);
        reset_n_i <= 1'b1;
        rc(5'h1B, 16'h0000);
        wr(REG_CTRL, 16'h0001);
        wr(REG_ZERO_SPD, 16'h0032);
        wr(REG_AT_CTR, 16'h03E8);
        wr(REG_AT_WID, 16'h0064);
        for (int i = 0; i < 10; i++) begin
            s = (i < 6) ? sp[i] : $urandom_range(1200);
            spd <= 16'(s);
            wt(3);
            `CHK("zero", 1'(s <= 50), zs)
            `CHK("window", exp_as(s), ash)
        end
        wr(REG_CTRL, 16'h0010);
        spd <= 16'sh0000;
        wt(3);
        `CHK("zero_torque", 1'b0, zs)
        for (int k = 0; k < 9; k++) begin
            @(posedge clk_i);
            fault_i <= 1'b1;
            code <= 8'($urandom_range(255, 1));
            wt(1);
            fault_i <= 1'b0;
            hq.push_front(code);
            if (hq.size() > 8) void'(hq.pop_back());
            `CHK("drive_en", 1'b0, en)
        end
        for (int i = 0; i < 8; i++) rc(REG_HIST0 + 5'(i), {8'h00, hq[i]});
        wr(REG_CMD, 16'h0001);
        rc(REG_HIST0, 16'h0000);
        wr(REG_CTRL, 16'h0000);
        wr(REG_PE_LIM, 16'h000A);
        wr(REG_PE_TIME, 16'h0002);
        wr(REG_POS_KP, 16'h0080);
        wr(REG_CTRL, 16'h0012);
        cmd <= 16'sh0064;
        wt(12);
        cmd <= 16'sh0000;
        wt(2);
        cmd <= 16'sh0064;
        wt(12);
        `CHK("pe_restart", 1'b0, flt)
        `CHK("comp", exp_p(100, 128), comp)
        wt(40);
        `CHK("pe_fault", 1'b1, flt)
        rc(REG_HIST0, {8'h00, FC_POS_ERR});
        wr(REG_CTRL, 16'h0000);
        wr(REG_PE_LIM, 16'h7FFF);
        wr(REG_PE2_LIM, 16'h000A);
        wr(REG_PE2_TIME, 16'h0002);
        wr(REG_CTRL, 16'h0016);
        wt(55);
        `CHK("pe2_fault", 1'b1, flt)
        wr(REG_CTRL, 16'h0000);
        press(2);
        press(0);
        for (int i = 0; i < 2600 && !led; i++) wt(1);
        `CHK("led", 1'b1, led)
        repeat (3) press(2);
        press(0);
        `CHK("baud", BAUD_9K6, baud)
        press(2);
        press(2);
        press(0);
        `CHK("temp", LOW_TEMP_INDICATION, disp.kind)
        plant.temp <= 8'($urandom_range(255, 41));
        wt(2);
        `CHK("temp_hi", DK_TEMP, disp.kind)
        press(0);
        `CHK("scroll", DK_NAME, disp.kind)
        repeat (2) press(2);
        press(0);
        `CHK("hall", 16'h0101, disp.val)
        press(0);
        repeat (2) press(2);
        press(0);
        `CHK("current", DK_CUR_DIS, disp.kind)
        press(0);
        press(2);
        press(0);
        `CHK("status", DK_DIS, disp.kind)
        press(0);
        repeat (2) press(2);
        press(0);
        `CHK("history", {8'h00, FC_POS_ERR}, disp.val)
        press(0);
        `CHK("comp_off", 16'h0000, comp)
        tally_and_finish();
    end
endmodule
`default_nettype wire

// file: verif/ssm_motor_model.sv
// servo motor with feedback: speed and position seen by the monitor
// assumes the bench sets target speed and position command
`default_nettype none
module ssm_motor_model (
    input  wire logic               clk_i,
    input  wire logic               drive_en_i,
    input  wire logic signed [15:0] spd_i,
    input  wire logic signed [15:0] cmd_i,
    output ssm_pkg::ssm_fb_type     fb_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import ssm_pkg::*;
    logic signed [15:0] pos_q = 16'sh0000;
    // shaft only turns while driven; counts wrap per turn
    always_ff @(posedge clk_i) if (drive_en_i) pos_q <= pos_q + (spd_i >>> 8);
    assign fb_o = '{spd_i, spd_i, cmd_i, pos_q, cmd_i - pos_q};
endmodule
`default_nettype wire
